// ===== xerc_top.v
// lap encapsulation, transmit monitor snapshot and committed-rate control
//
// Added by the designer: the AHB-Lite register port.
`timescale 1ns/100ps
`include "xerc_consts.vh"

// Contract
// - rising edge of monitor update bit copies counters and restarts them
// - done flag sets once the snapshot has been taken
// - done flag clears when software returns the update bit to zero
// - lap enable turns on transmit encoding and receive decoding together
// - lap mode wraps each frame in a header and checks received headers
// - far end marks receive byte boundaries; receive decoding aligns to them in lap mode only
// - in lap mode the block drives the transmit byte sync output
// - hdlc flag and escape framing is applied with lap mode on or off
// - address octet programmable, sent and expected, resets to 04
// - control octet programmable, sent and expected, resets to 03
// - upper sapi octet programmable, sent and expected, resets to fe
// - lower sapi octet programmable, sent and expected, resets to 01
// - rate limiter acts only while its enable bit is one
// - committed rate equals the seven-bit multiplier times 500 kbps
// - a rate above line rate adds no restriction
module xerc_top
(
   input  wire        clk,
   input  wire        rst_n,
   input  wire        hsel,
   input  wire [11:0] haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire [31:0] hwdata,
   input  wire        hready,
   output wire        hreadyout,
   output wire        hresp,
   output wire [31:0] hrdata,
   output wire        irq,
   input  wire [7:0]  tx_data,
   input  wire        tx_valid,
   input  wire        tx_last,
   output wire        tx_ready,
   input  wire        line_bit_en,
   output wire        tx_ser_out,
   output wire        tx_byte_sync_out,
   input  wire        rx_bit_en,
   input  wire        rx_ser_in,
   input  wire        rx_byte_sync_in,
   output wire [7:0]  rx_data,
   output wire        rx_valid,
   output wire        rx_frame_end
);

   // =====================================================================
   // state codes
   localparam [4:0] TX_IDLE = 5'h01;
   localparam [4:0] TX_HDR  = 5'h02;
   localparam [4:0] TX_PAY  = 5'h04;
   localparam [4:0] TX_ESC  = 5'h08;
   localparam [4:0] TX_SPR  = 5'h10;
   localparam [3:0] RX_HUNT = 4'h1;
   localparam [3:0] RX_HDR  = 4'h2;
   localparam [3:0] RX_DATA = 4'h4;
   localparam [3:0] RX_ESC  = 4'h8;

   function needs_escape;
      input [7:0] b;
      begin
         needs_escape = (b == `XERC_FLAG) || (b == `XERC_ESC);
      end
   endfunction

   // =====================================================================
   // registers
   reg         mon_trig_ff;
   reg         mon_trig_prev_ff;
   reg         mon_snap_d_ff;
   reg         mon_done_ff;
   reg         lap_en_ff;
   reg  [7:0]  lap_addr_ff;
   reg  [7:0]  lap_ctl_ff;
   reg  [7:0]  sapi_hi_ff;
   reg  [7:0]  sapi_lo_ff;
   reg  [7:0]  rate_ff;
   reg  [`XERC_IRQ_W-1:0] irq_sts_ff;
   reg  [`XERC_IRQ_W-1:0] irq_msk_ff;
   reg  [23:0] pkt_cnt_ff;
   reg  [31:0] byte_cnt_ff;
   reg  [23:0] pkt_snap_ff;
   reg  [31:0] byte_snap_ff;

   // =====================================================================
   // ahb-lite slave: writes zero wait, reads one wait state
   reg         wr_pend_ff;
   reg         rd_pend_ff;
   reg  [7:0]  wr_idx_ff;
   reg  [7:0]  rd_idx_ff;
   reg  [31:0] hrdata_ff;
   reg  [7:0]  rd_val;
   wire        addr_ok;
   wire        access;
   wire        wr_hit;

   assign addr_ok   = (haddr[11:10] == 2'b00) && (haddr[1:0] == 2'b00);
   assign access    = hsel && hready && htrans[1] && addr_ok;
   assign hreadyout = !rd_pend_ff;
   assign hresp     = 1'b0;
   assign hrdata    = hrdata_ff;
   assign wr_hit    = wr_pend_ff;

   always @(posedge clk)
   begin
      if (!rst_n)
      begin
         wr_pend_ff <= 1'b0;
         rd_pend_ff <= 1'b0;
         wr_idx_ff  <= 8'h00;
         rd_idx_ff  <= 8'h00;
         hrdata_ff  <= 32'h00000000;
      end
      else
      begin
         wr_pend_ff <= access && hwrite;
         rd_pend_ff <= access && !hwrite;
         if (access)
         begin
            wr_idx_ff <= haddr[9:2];
            rd_idx_ff <= haddr[9:2];
         end
         // value sampled in the wait cycle so a preceding write is seen
         if (rd_pend_ff)
         begin
            hrdata_ff <= {24'h000000, rd_val};
         end
      end
   end

   always @*
   begin
      case (rd_idx_ff)
         `XERC_IDX_PKT0     : rd_val = pkt_snap_ff[7:0];
         `XERC_IDX_PKT1     : rd_val = pkt_snap_ff[15:8];
         `XERC_IDX_PKT2     : rd_val = pkt_snap_ff[23:16];
         `XERC_IDX_BYT0     : rd_val = byte_snap_ff[7:0];
         `XERC_IDX_BYT1     : rd_val = byte_snap_ff[15:8];
         `XERC_IDX_BYT2     : rd_val = byte_snap_ff[23:16];
         `XERC_IDX_BYT3     : rd_val = byte_snap_ff[31:24];
         `XERC_IDX_MON_TRIG : rd_val = {7'h00, mon_trig_ff};
         `XERC_IDX_MON_DONE : rd_val = {7'h00, mon_done_ff};
         `XERC_IDX_LAP_EN   : rd_val = {7'h00, lap_en_ff};
         `XERC_IDX_LAP_ADDR : rd_val = lap_addr_ff;
         `XERC_IDX_LAP_CTL  : rd_val = lap_ctl_ff;
         `XERC_IDX_SAPI_HI  : rd_val = sapi_hi_ff;
         `XERC_IDX_SAPI_LO  : rd_val = sapi_lo_ff;
         `XERC_IDX_RATE     : rd_val = rate_ff;
         `XERC_IDX_IRQ_STS  : rd_val = {3'h0, irq_sts_ff};
         `XERC_IDX_IRQ_MSK  : rd_val = {3'h0, irq_msk_ff};
         default            : rd_val = 8'h00;
      endcase
   end

   always @(posedge clk)
   begin
      if (!rst_n)
      begin
         mon_trig_ff <= 1'b0;
         lap_en_ff   <= 1'b0;
         lap_addr_ff <= `XERC_RST_LAP_ADDR;
         lap_ctl_ff  <= `XERC_RST_LAP_CTL;
         sapi_hi_ff  <= `XERC_RST_SAPI_HI;
         sapi_lo_ff  <= `XERC_RST_SAPI_LO;
         rate_ff     <= `XERC_RST_RATE;
         irq_msk_ff  <= {`XERC_IRQ_W{1'b0}};
      end
      else if (wr_hit)
      begin
         case (wr_idx_ff)
            `XERC_IDX_MON_TRIG : mon_trig_ff <= hwdata[0];
            `XERC_IDX_LAP_EN   : lap_en_ff   <= hwdata[0];
            `XERC_IDX_LAP_ADDR : lap_addr_ff <= hwdata[7:0];
            `XERC_IDX_LAP_CTL  : lap_ctl_ff  <= hwdata[7:0];
            `XERC_IDX_SAPI_HI  : sapi_hi_ff  <= hwdata[7:0];
            `XERC_IDX_SAPI_LO  : sapi_lo_ff  <= hwdata[7:0];
            `XERC_IDX_RATE     : rate_ff     <= hwdata[7:0];
            `XERC_IDX_IRQ_MSK  : irq_msk_ff  <= hwdata[`XERC_IRQ_W-1:0];
            default            : ;
         endcase
      end
   end

   // =====================================================================
   // transmit monitor counters and snapshot
   wire tx_pop;
   wire tx_frame_done;
   wire mon_snap;

   assign mon_snap = mon_trig_ff && !mon_trig_prev_ff;

   always @(posedge clk)
   begin
      if (!rst_n)
      begin
         mon_trig_prev_ff <= 1'b0;
         mon_snap_d_ff    <= 1'b0;
         mon_done_ff      <= 1'b0;
         pkt_cnt_ff       <= 24'h000000;
         byte_cnt_ff      <= 32'h00000000;
         pkt_snap_ff      <= 24'h000000;
         byte_snap_ff     <= 32'h00000000;
      end
      else
      begin
         mon_trig_prev_ff <= mon_trig_ff;
         mon_snap_d_ff    <= mon_snap;
         // set wins over the clear from a falling update bit
         mon_done_ff      <= mon_snap_d_ff || (mon_done_ff && mon_trig_ff);
         if (mon_snap)
         begin
            // an event in the snapshot cycle restarts the count at one
            pkt_snap_ff  <= pkt_cnt_ff;
            byte_snap_ff <= byte_cnt_ff;
            pkt_cnt_ff   <= {23'h000000, tx_frame_done};
            byte_cnt_ff  <= {31'h00000000, tx_pop};
         end
         else
         begin
            pkt_cnt_ff  <= pkt_cnt_ff + {23'h000000, tx_frame_done};
            byte_cnt_ff <= byte_cnt_ff + {31'h00000000, tx_pop};
         end
      end
   end

   // =====================================================================
   // transmit framer and serialiser
   reg  [4:0] tx_st_ff;
   reg  [4:0] nxt_tx_st;
   reg  [1:0] hdr_idx_ff;
   reg  [2:0] tx_bit_ff;
   reg  [7:0] tx_sh_ff;
   reg        tx_sync_ff;
   reg        tx_under_ff;
   reg  [7:0] load_byte;
   reg        pop;
   reg        under;
   reg        consume;
   wire       load;
   wire       allow;

   assign load = line_bit_en && (tx_bit_ff == 3'h0);

   xerc_rate_limiter u_rate
   (
      .clk        (clk),
      .rst_n      (rst_n),
      .enable     (rate_ff[`XERC_RATE_EN_BIT]),
      .multiplier (rate_ff[6:0]),
      .consume    (consume),
      .allow      (allow)
   );

   always @*
   begin
      nxt_tx_st = tx_st_ff;
      load_byte = `XERC_FLAG;
      pop       = 1'b0;
      under     = 1'b0;
      consume   = 1'b0;
      case (tx_st_ff)
         TX_IDLE :
            // idle fill doubles as the opening flag; start waits for credit
            if (tx_valid && allow)
            begin
               nxt_tx_st = lap_en_ff ? TX_HDR : TX_PAY;
            end
         TX_HDR :
         begin
            consume = 1'b1;
            case (hdr_idx_ff)
               2'h0    : load_byte = lap_addr_ff;
               2'h1    : load_byte = lap_ctl_ff;
               2'h2    : load_byte = sapi_hi_ff;
               default : load_byte = sapi_lo_ff;
            endcase
            if (hdr_idx_ff == 2'h3)
            begin
               nxt_tx_st = TX_PAY;
            end
         end
         TX_PAY :
            if (!tx_valid)
            begin
               // line cannot stall: truncate with a flag and flag it
               under     = 1'b1;
               nxt_tx_st = TX_IDLE;
            end
            else if (needs_escape(tx_data))
            begin
               load_byte = `XERC_ESC;
               consume   = 1'b1;
               nxt_tx_st = TX_ESC;
            end
            else
            begin
               load_byte = tx_data;
               pop       = 1'b1;
               consume   = 1'b1;
               nxt_tx_st = tx_last ? TX_IDLE : TX_PAY;
            end
         TX_ESC :
         begin
            load_byte = tx_data ^ `XERC_ESC_XOR;
            pop       = 1'b1;
            consume   = 1'b1;
            nxt_tx_st = tx_last ? TX_IDLE : TX_PAY;
         end
         default :
            nxt_tx_st = TX_IDLE;
      endcase
      if (!load)
      begin
         nxt_tx_st = tx_st_ff;
         pop       = 1'b0;
         under     = 1'b0;
         consume   = 1'b0;
      end
   end

   assign tx_pop        = pop;
   assign tx_ready      = pop;
   assign tx_frame_done = pop && tx_last;

   always @(posedge clk)
   begin
      if (!rst_n)
      begin
         tx_st_ff    <= TX_IDLE;
         hdr_idx_ff  <= 2'h0;
         tx_bit_ff   <= 3'h0;
         tx_sh_ff    <= `XERC_FLAG;
         tx_sync_ff  <= 1'b0;
         tx_under_ff <= 1'b0;
      end
      else
      begin
         tx_st_ff    <= nxt_tx_st;
         tx_under_ff <= under;
         if (load)
         begin
            hdr_idx_ff <= (tx_st_ff == TX_HDR) ? hdr_idx_ff + 2'h1 : 2'h0;
         end
         if (line_bit_en)
         begin
            tx_bit_ff  <= tx_bit_ff + 3'h1;
            tx_sh_ff   <= load ? load_byte : {tx_sh_ff[6:0], 1'b0};
            tx_sync_ff <= load && lap_en_ff;
         end
      end
   end

   assign tx_ser_out       = tx_sh_ff[7];
   assign tx_byte_sync_out = tx_sync_ff;

   // =====================================================================
   // receive pins: two-stage synchronisers, enable delayed to match
   reg  [1:0] rx_ser_sync_ff;
   reg  [1:0] rx_bsync_sync_ff;
   reg  [1:0] rx_en_dly_ff;
   reg  [2:0] rx_bit_ff;
   reg  [7:0] rx_sh_ff;
   reg        rx_byte_vld_ff;
   wire [7:0] rx_sh_next;

   assign rx_sh_next = {rx_sh_ff[6:0], rx_ser_sync_ff[1]};

   always @(posedge clk)
   begin
      if (!rst_n)
      begin
         rx_ser_sync_ff   <= 2'b00;
         rx_bsync_sync_ff <= 2'b00;
         rx_en_dly_ff     <= 2'b00;
         rx_bit_ff        <= 3'h0;
         rx_sh_ff         <= 8'h00;
         rx_byte_vld_ff   <= 1'b0;
      end
      else
      begin
         rx_ser_sync_ff   <= {rx_ser_sync_ff[0], rx_ser_in};
         rx_bsync_sync_ff <= {rx_bsync_sync_ff[0], rx_byte_sync_in};
         rx_en_dly_ff     <= {rx_en_dly_ff[0], rx_bit_en};
         rx_byte_vld_ff   <= 1'b0;
         if (rx_en_dly_ff[1])
         begin
            rx_sh_ff <= rx_sh_next;
            // sync marks the first bit of a byte and realigns the count
            if (lap_en_ff && rx_bsync_sync_ff[1])
            begin
               rx_bit_ff <= 3'h1;
            end
            else
            begin
               rx_bit_ff      <= rx_bit_ff + 3'h1;
               rx_byte_vld_ff <= (rx_bit_ff == 3'h7);
            end
         end
      end
   end

   // =====================================================================
   // receive deframer and header check
   reg  [3:0] rx_st_ff;
   reg  [1:0] rx_hidx_ff;
   reg  [7:0] rx_data_ff;
   reg        rx_valid_ff;
   reg        rx_end_ff;
   reg        rx_err_ff;
   reg  [7:0] rx_expect;

   always @*
   begin
      case (rx_hidx_ff)
         2'h0    : rx_expect = lap_addr_ff;
         2'h1    : rx_expect = lap_ctl_ff;
         2'h2    : rx_expect = sapi_hi_ff;
         default : rx_expect = sapi_lo_ff;
      endcase
   end

   always @(posedge clk)
   begin
      if (!rst_n)
      begin
         rx_st_ff    <= RX_HUNT;
         rx_hidx_ff  <= 2'h0;
         rx_data_ff  <= 8'h00;
         rx_valid_ff <= 1'b0;
         rx_end_ff   <= 1'b0;
         rx_err_ff   <= 1'b0;
      end
      else
      begin
         rx_valid_ff <= 1'b0;
         rx_end_ff   <= 1'b0;
         rx_err_ff   <= 1'b0;
         if (rx_byte_vld_ff)
         begin
            case (rx_st_ff)
               RX_HUNT :
                  if (rx_sh_ff == `XERC_FLAG)
                  begin
                     rx_st_ff   <= lap_en_ff ? RX_HDR : RX_DATA;
                     rx_hidx_ff <= 2'h0;
                  end
               RX_HDR :
                  if (rx_sh_ff == `XERC_FLAG)
                  begin
                     rx_hidx_ff <= 2'h0;
                  end
                  else if (rx_sh_ff != rx_expect)
                  begin
                     rx_err_ff <= 1'b1;
                     rx_st_ff  <= RX_HUNT;
                  end
                  else
                  begin
                     rx_hidx_ff <= rx_hidx_ff + 2'h1;
                     if (rx_hidx_ff == 2'h3)
                     begin
                        rx_st_ff <= RX_DATA;
                     end
                  end
               RX_DATA :
                  if (rx_sh_ff == `XERC_FLAG)
                  begin
                     rx_end_ff  <= 1'b1;
                     rx_st_ff   <= lap_en_ff ? RX_HDR : RX_DATA;
                     rx_hidx_ff <= 2'h0;
                  end
                  else if (rx_sh_ff == `XERC_ESC)
                  begin
                     rx_st_ff <= RX_ESC;
                  end
                  else
                  begin
                     rx_data_ff  <= rx_sh_ff;
                     rx_valid_ff <= 1'b1;
                  end
               RX_ESC :
               begin
                  rx_data_ff  <= rx_sh_ff ^ `XERC_ESC_XOR;
                  rx_valid_ff <= 1'b1;
                  rx_st_ff    <= RX_DATA;
               end
               default :
                  rx_st_ff <= RX_HUNT;
            endcase
         end
      end
   end

   assign rx_data      = rx_data_ff;
   assign rx_valid     = rx_valid_ff;
   assign rx_frame_end = rx_end_ff;

   // =====================================================================
   // interrupt status: sticky, write one to clear, set wins
   wire [`XERC_IRQ_W-1:0] irq_set;
   wire [`XERC_IRQ_W-1:0] irq_clr;

   assign irq_set = {rx_err_ff, rx_end_ff, tx_under_ff, tx_frame_done, mon_snap_d_ff};
   assign irq_clr = (wr_hit && (wr_idx_ff == `XERC_IDX_IRQ_STS)) ?
                    hwdata[`XERC_IRQ_W-1:0] : {`XERC_IRQ_W{1'b0}};

   always @(posedge clk)
   begin
      if (!rst_n)
      begin
         irq_sts_ff <= {`XERC_IRQ_W{1'b0}};
      end
      else
      begin
         irq_sts_ff <= irq_set | (irq_sts_ff & ~irq_clr);
      end
   end

   assign irq = |(irq_sts_ff & irq_msk_ff);

endmodule

// ===== xerc_consts.vh
// constants for the lap encapsulation and committed-rate block
`ifndef XERC_CONSTS_VH
`define XERC_CONSTS_VH

// register indices; byte address is four times the index
`define XERC_IDX_PKT0       8'hcc
`define XERC_IDX_PKT1       8'hcd
`define XERC_IDX_PKT2       8'hce
`define XERC_IDX_BYT0       8'hd0
`define XERC_IDX_BYT1       8'hd1
`define XERC_IDX_BYT2       8'hd2
`define XERC_IDX_BYT3       8'hd3
`define XERC_IDX_MON_TRIG   8'hd6
`define XERC_IDX_MON_DONE   8'hd7
`define XERC_IDX_LAP_EN     8'hd8
`define XERC_IDX_LAP_ADDR   8'hd9
`define XERC_IDX_LAP_CTL    8'hda
`define XERC_IDX_SAPI_HI    8'hdb
`define XERC_IDX_SAPI_LO    8'hdc
`define XERC_IDX_RATE       8'hdd
`define XERC_IDX_IRQ_STS    8'he0
`define XERC_IDX_IRQ_MSK    8'he1

// reset values
`define XERC_RST_LAP_ADDR   8'h04
`define XERC_RST_LAP_CTL    8'h03
`define XERC_RST_SAPI_HI    8'hfe
`define XERC_RST_SAPI_LO    8'h01
`define XERC_RST_RATE       8'h01

// field positions
`define XERC_RATE_EN_BIT    7
`define XERC_IRQ_MON_DONE   0
`define XERC_IRQ_TX_FRAME   1
`define XERC_IRQ_TX_UNDER   2
`define XERC_IRQ_RX_FRAME   3
`define XERC_IRQ_RX_HDR_ERR 4
`define XERC_IRQ_W          5

// framing octets
`define XERC_FLAG           8'h7e
`define XERC_ESC            8'h7d
`define XERC_ESC_XOR        8'h20

// timing: clock rate, rate step, credit ceiling in bytes
`define XERC_CLK_HZ         125000000
`define XERC_RATE_STEP_BPS  500000
`define XERC_CREDIT_CAP     64

`endif

// ===== xerc_rate_limiter.v
// byte-credit bucket that paces transmit frames to the committed rate
`timescale 1ns/100ps
`include "xerc_consts.vh"

module xerc_rate_limiter
(
   input  wire       clk,
   input  wire       rst_n,
   input  wire       enable,
   input  wire [6:0] multiplier,
   input  wire       consume,
   output wire       allow
);

   // one rate step earns a byte of credit every this many cycles
   localparam integer CYC_PER_STEP = (`XERC_CLK_HZ * 8) / `XERC_RATE_STEP_BPS;
   localparam [11:0]  STEP_LIMIT   = CYC_PER_STEP[11:0];
   localparam integer CAP_BYTES    = `XERC_CREDIT_CAP;
   localparam [19:0]  CREDIT_CAP   = CAP_BYTES[19:0];

   reg  [11:0] acc_ff;
   reg  [19:0] credit_ff;
   reg  [11:0] nxt_acc;
   reg  [19:0] nxt_credit;
   wire [11:0] acc_sum;
   wire        earn;

   assign acc_sum = acc_ff + {5'h00, multiplier};
   assign earn    = (acc_sum >= STEP_LIMIT);

   always @*
   begin
      nxt_acc    = earn ? (acc_sum - STEP_LIMIT) : acc_sum;
      nxt_credit = credit_ff;
      // credit may go negative inside a frame; next frame waits to repay it
      if (earn && ($signed(credit_ff) < $signed(CREDIT_CAP)))
      begin
         nxt_credit = nxt_credit + 20'h00001;
      end
      if (consume)
      begin
         nxt_credit = nxt_credit - 20'h00001;
      end
   end

   always @(posedge clk)
   begin
      if (!rst_n || !enable)
      begin
         acc_ff    <= 12'h000;
         credit_ff <= 20'h00000;
      end
      else
      begin
         acc_ff    <= nxt_acc;
         credit_ff <= nxt_credit;
      end
   end

   // rates above the line rate leave credit full, so the line sets the pace
   assign allow = !enable || !credit_ff[19];

endmodule

// ===== xerc_top_chk.sv
// port checker for the lap encapsulation block
`timescale 1ns/100ps
// ====
// checker
module xerc_top_chk
(
   input logic        clk,
   input logic        rst_n,
   input logic        hsel,
   input logic [11:0] haddr,
   input logic [1:0]  htrans,
   input logic        hwrite,
   input logic        hready,
   input logic        hreadyout,
   input logic [31:0] hrdata,
   input logic        irq,
   input logic        tx_valid,
   input logic        tx_ready,
   input logic        line_bit_en,
   input logic        tx_ser_out,
   input logic        tx_byte_sync_out,
   input logic        rx_valid,
   input logic        rx_frame_end
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   sequence s_req;
      hsel && hready && htrans[1] && haddr[11:10] == 2'h0 && haddr[1:0] == 2'h0;
   endsequence
   sequence s_wait;
      !hreadyout ##1 hreadyout;
   endsequence
   a_read_wait: assert property (s_req ##0 !hwrite |=> s_wait)
      else $error("read not answered after one wait");
   a_write_nowait: assert property (s_req ##0 hwrite |=> hreadyout)
      else $error("write stalled");
   a_rdata_hold: assert property (!$stable(hrdata) |-> !$past(hreadyout))
      else $error("read data moved outside a read");
   a_take_bit: assert property (tx_ready |-> line_bit_en && tx_valid)
      else $error("byte taken off a bit slot");
   a_ser_paced: assert property (!$stable({tx_ser_out, tx_byte_sync_out})
      |-> $past(line_bit_en))
      else $error("serial output moved off a bit slot");
   a_rxv_pulse: assert property (rx_valid |=> !rx_valid)
      else $error("rx_valid longer than one cycle");
   a_end_pulse: assert property (rx_frame_end |=> !rx_frame_end)
      else $error("frame end longer than one cycle");
   a_rst_quiet: assert property ($rose(rst_n) |-> !irq && hreadyout && !tx_byte_sync_out)
      else $error("outputs not idle after reset");
endmodule
bind xerc_top xerc_top_chk u_chk (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
   .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
   .hrdata(hrdata), .irq(irq), .tx_valid(tx_valid), .tx_ready(tx_ready),
   .line_bit_en(line_bit_en), .tx_ser_out(tx_ser_out), .tx_byte_sync_out(tx_byte_sync_out),
   .rx_valid(rx_valid), .rx_frame_end(rx_frame_end));

// ===== xerc_line_model.sv
// serial line partner: paces both bit streams, loops transmit to receive
`timescale 1ns/100ps
// ====
// line model
module xerc_line_model
(
   input  logic clk,
   input  logic rst_n,
   input  logic tx_ser_out,
   input  logic tx_byte_sync_out,
   output logic line_bit_en = 1'b0,
   output logic rx_bit_en = 1'b0,
   output logic rx_ser_in = 1'b0,
   output logic rx_byte_sync_in = 1'b0
);
   logic [1:0] cnt_ff;
   // sample one clock into each four-clock bit so the looped bit has settled a full clock
   always @(posedge clk)
   begin
      cnt_ff <= rst_n ? cnt_ff + 2'h1 : 2'h0;
      line_bit_en <= rst_n && cnt_ff == 2'h3;
      rx_bit_en <= rst_n && cnt_ff == 2'h1;
      if (!rst_n || cnt_ff == 2'h1)
      begin
         rx_ser_in <= rst_n & tx_ser_out;
         rx_byte_sync_in <= rst_n & tx_byte_sync_out;
      end
   end
endmodule

// ===== x86_encap_rate_control_tb_top.sv
// self-checking bench for the lap encapsulation block
`timescale 1ns/100ps
module x86_encap_rate_control_tb_top;
   logic        clk = 0, rst_n = 0, hsel = 0, hwrite = 0, tx_valid = 0, tx_last = 0;
   logic [11:0] haddr = 0;
   logic [1:0]  htrans = 0;
   logic [31:0] hwdata = 0, hrdata, rdv;
   logic [7:0]  tx_data = 0, rx_data, v;
   logic        hreadyout, hresp, irq, tx_ready, line_bit_en, tx_ser_out, tx_byte_sync_out;
   logic        rx_bit_en, rx_ser_in, rx_byte_sync_in, rx_valid, rx_frame_end;
   int          fails = 0, samples_checked = 0, seed = 34, syncs = 0, ends = 0, cyc, k;
   logic [7:0]  exp_q[$], rx_q[$];
   logic [7:0]  ix[8] = '{8'hd7, 8'hd8, 8'hd9, 8'hda, 8'hdb, 8'hdc, 8'hdd, 8'hf0};
   logic [7:0]  rv[8] = '{8'h00, 8'h00, 8'h04, 8'h03, 8'hfe, 8'h01, 8'h01, 8'h00};
   xerc_top dut (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq(irq), .tx_data(tx_data),
      .tx_valid(tx_valid), .tx_last(tx_last), .tx_ready(tx_ready), .line_bit_en(line_bit_en),
      .tx_ser_out(tx_ser_out), .tx_byte_sync_out(tx_byte_sync_out), .rx_bit_en(rx_bit_en),
      .rx_ser_in(rx_ser_in), .rx_byte_sync_in(rx_byte_sync_in), .rx_data(rx_data),
      .rx_valid(rx_valid), .rx_frame_end(rx_frame_end));
   xerc_line_model line (.clk(clk), .rst_n(rst_n), .tx_ser_out(tx_ser_out),
      .tx_byte_sync_out(tx_byte_sync_out), .line_bit_en(line_bit_en), .rx_bit_en(rx_bit_en),
      .rx_ser_in(rx_ser_in), .rx_byte_sync_in(rx_byte_sync_in));
   always #4 clk = ~clk;
   always @(posedge clk)
   begin
      if (rx_valid)
         rx_q.push_back(rx_data);
      ends <= ends + rx_frame_end;
      syncs <= syncs + tx_byte_sync_out;
   end
   // ====
   // tasks
   task chk(input logic [31:0] g, e);
   begin
      samples_checked++;
      if (g !== e)
      begin
         fails++;
         $display("FAIL %0t got %h exp %h", $time, g, e);
      end
   end
   endtask
   task test_done;
   begin
      if (fails == 0 && samples_checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   end
   endtask
   task tick(inout int n);
   begin
      @(posedge clk);
      n++;
      if (n > 30000)
      begin
         chk(n, 0);
         test_done;
      end
   end
   endtask
   task bus(input logic w, input logic [7:0] i, input logic [31:0] d);
      int n;
   begin
      n = 0;
      hsel <= 1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {2'h0, i, 2'h0};
      do tick(n); while (hreadyout !== 1'b1);
      hsel <= 0;
      htrans <= 2'h0;
      hwdata <= d;
      do tick(n); while (hreadyout !== 1'b1);
      rdv = hrdata;
      chk(hresp, 0);
   end
   endtask
   // poll bound ends in a failing compare, not a hang
   task poll(input logic [7:0] i, m);
      int n;
   begin
      n = 0;
      do bus(0, i, 0); while ((rdv & m) == 0 && ++n < 500);
      chk(rdv & m, m);
   end
   endtask
   task send(input int n);
      int t;
   begin
      for (int i = 0; i < n; i++)
      begin
         t = 0;
         tx_data <= $random(seed);
         tx_valid <= 1;
         tx_last <= i == n - 1;
         do tick(t); while (tx_ready !== 1'b1);
         exp_q.push_back(tx_data);
      end
   end
   endtask
   // credit cap bounds how far ahead four 44-byte frames can run
   function int lim(input int m);
      return (3 * 44 - 64) * 2000 / m;
   endfunction
   task burst(input logic [7:0] r);
   begin
      bus(1, 8'hdd, r);
      cyc = $time;
      repeat (4) send(40);
      tx_valid <= 0;
      cyc = ($time - cyc) / 8;
   end
   endtask
   // ====
   // sequence
   initial
   begin
      repeat (10) @(posedge clk);
      rst_n <= 1;
      @(posedge clk);
      foreach (ix[i])
      begin
         bus(0, ix[i], 0);
         chk(rdv, rv[i]);
      end
      send(6);
      tx_valid <= 0;
      chk(syncs, 0);
      poll(8'he0, 8'h02);
      for (int i = 9; i < 13; i++)
      begin
         v = $random(seed) & 8'h3f;
         bus(1, 8'hd0 + i, v);
         bus(0, 8'hd0 + i, 0);
         chk(rdv, v);
      end
      bus(1, 8'he1, 1);
      bus(1, 8'he0, 8'h1f);
      bus(1, 8'hd6, 1);
      poll(8'hd7, 1);
      @(posedge clk);
      chk(irq, 1);
      bus(1, 8'hd6, 0);
      bus(0, 8'hd7, 0);
      chk(rdv, 0);
      bus(1, 8'he0, 1);
      @(posedge clk);
      chk(irq, 0);
      bus(1, 8'hd8, 1);
      rx_q.delete();
      exp_q.delete();
      k = 0;
      cyc = ends;
      send(12);
      tx_valid <= 0;
      while (ends == cyc)
         tick(k);
      chk(rx_q.size(), 12);
      foreach (rx_q[i])
         chk(rx_q[i], exp_q[i]);
      chk(syncs > 0, 1);
      bus(1, 8'hd6, 1);
      poll(8'hd7, 1);
      bus(0, 8'hcc, 0);
      chk(rdv, 1);
      bus(0, 8'hd0, 0);
      chk(rdv, 12);
      bus(1, 8'hd6, 0);
      // frame left open mid-payload must close with a flag and flag underrun
      k = 0;
      tx_last <= 0;
      tx_valid <= 1;
      do tick(k); while (tx_ready !== 1'b1);
      tx_valid <= 0;
      poll(8'he0, 8'h04);
      burst(8'h80 | 8'd13);
      chk(cyc >= lim(13), 1);
      burst(8'd13);
      chk(cyc < lim(13), 1);
      burst(8'h80 | 8'd104);
      chk(cyc < lim(13), 1);
      test_done;
   end
endmodule
